// file: hdl/boundary_run_test_engine.sv
`timescale 1ns/100ps
// What this block does
// - Operation comes from the low three select bits, bit 2 most significant.
// - Operation runs only with run-test instruction loaded and TAP in idle.
// - Codes X00, X01, X10 pick toggle, 36-bit pattern, 36-bit signature.
// - Code 011 is signature plus pattern; code 111 is signature plus count.
// - Control cells 47 to 36 never take part in any algorithm.
// - Enable cells 47 to 44 decide which pin groups are driven.
// - Run only with one shared direction per byte; else behave as bypass.
// - Toggle mode: input-mode cells capture their pins on each rising edge.
// - Toggle mode: output cells invert on rise, reach latches and pins on fall.
// - 36-bit pattern register steps on rise; output-side latches and pins update on fall.
// - An all-zero seed stays all zero in both pattern modes.
// - 36-bit signature folds input pins into the cells on each rise.
// - 36-bit signature mode holds output latches and keeps driving them.
// - Both combined modes fold input pins into an 18-bit signature.
// - Signature-plus-pattern steps 18-bit pattern on rise, drives on fall.
// - Signature-plus-count increments 18-bit count on rise, drives on fall.
// - Direction A-to-B or reverse picks input side, output side and feedback.
// - An enable cell at zero makes its pins outputs; otherwise inputs.
// - A boundary read leaves the chain untouched at capture.
module boundary_run_test_engine (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Test port side: test clock, instruction and TAP state, pins
  input wire brt_pkg::link_in_t i_link,
  // Select register contents
  input wire logic [2:0] i_test_op_select_reg,
  // Chain load from the scan path
  input wire logic i_load_valid,
  input wire logic [brt_pkg::CHAIN_W-1:0] i_load_chain,
  input wire logic i_read_capture,
  // Pin drive
  output brt_pkg::pin_out_t o_pins,
  // Chain state and status
  output logic [brt_pkg::CHAIN_W-1:0] o_boundary_chain,
  output logic [brt_pkg::CHAIN_W-1:0] o_shadow,
  output logic o_running,
  output logic o_bypass_active,
  output logic o_a_to_b
);

  typedef struct packed {
    logic [brt_pkg::CHAIN_W-1:0] shift;
    logic [brt_pkg::CHAIN_W-1:0] shadow;
  } engine_t;

  engine_t st;
  engine_t next_st;
  brt_pkg::link_in_t sy;
  logic tck_rise;
  logic tck_fall;
  logic [brt_pkg::LINK_W-1:0] sync_bits;
  logic [brt_pkg::LINK_W-1:0] link_bits;

  // ****************************************************************
  // Link sampling
  // ****************************************************************
  // The test clock sits in bit 0 so the sampler can find its edges.
  assign link_bits = {
    i_link.a,
    i_link.b,
    i_link.idle,
    i_link.run,
    i_link.tck
  };

  // The test clock is slow against the local clock, so it is sampled and
  // its edges found here rather than used as a clock of its own.
  link_sampler #(
    .W(brt_pkg::LINK_W)
  ) u_sampler (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(link_bits),
    .o_sync(sync_bits),
    .o_rise(tck_rise),
    .o_fall(tck_fall)
  );

  always_comb begin
    sy.tck = sync_bits[0];
    sy.run = sync_bits[1];
    sy.idle = sync_bits[2];
    sy.b = sync_bits[3 +: brt_pkg::HALF_W];
    sy.a = sync_bits[3 + brt_pkg::HALF_W +: brt_pkg::HALF_W];
  end

  // ****************************************************************
  // Feedback functions
  // ****************************************************************
  // An all-zero register feeds back zero, so a zero seed stays at zero.
  function automatic logic [brt_pkg::DATA_W-1:0] step36(
    input logic [brt_pkg::DATA_W-1:0] v
  );
    logic fb;
    fb = v[brt_pkg::TAP36_HI] ^ v[brt_pkg::TAP36_LO];
    step36 = {v[brt_pkg::DATA_W-2:0], fb};
  endfunction

  function automatic logic [brt_pkg::HALF_W-1:0] step18(
    input logic [brt_pkg::HALF_W-1:0] v
  );
    logic fb;
    fb = v[brt_pkg::TAP18_HI] ^ v[brt_pkg::TAP18_LO];
    step18 = {v[brt_pkg::HALF_W-2:0], fb};
  endfunction

  function automatic brt_pkg::test_op_t decode_op(input logic [2:0] code);
    case (code[1:0])
      brt_pkg::LOW_TOGGLE: begin
        decode_op = brt_pkg::OP_TOGGLE;
      end
      brt_pkg::LOW_PATTERN: begin
        decode_op = brt_pkg::OP_PATTERN36;
      end
      brt_pkg::LOW_SIGNATURE: begin
        decode_op = brt_pkg::OP_SIGNATURE36;
      end
      default: begin
        // Only here does bit 2 matter: it picks the count over the pattern.
        if (code == brt_pkg::CODE_SIG_PATTERN) begin
          decode_op = brt_pkg::OP_SIG_PATTERN;
        end else if (code == brt_pkg::CODE_SIG_COUNT) begin
          decode_op = brt_pkg::OP_SIG_COUNT;
        end else begin
          decode_op = brt_pkg::OP_TOGGLE;
        end
      end
    endcase
  endfunction

  // ****************************************************************
  // Engine
  // ****************************************************************
  brt_pkg::test_op_t op;
  logic b1_ab_n;
  logic b2_ab_n;
  logic b1_ba_n;
  logic b2_ba_n;
  logic byte1_one_dir;
  logic byte2_one_dir;
  logic bytes_agree;
  logic dir_valid;
  logic a_to_b;
  logic running;

  // The enable cells do not move during a run, so the applied latch values
  // are the ones that steer direction and drive.
  always_comb begin
    op = decode_op(i_test_op_select_reg);
    b1_ab_n = st.shadow[brt_pkg::POS_B1_AB_N];
    b2_ab_n = st.shadow[brt_pkg::POS_B2_AB_N];
    b1_ba_n = st.shadow[brt_pkg::POS_B1_BA_N];
    b2_ba_n = st.shadow[brt_pkg::POS_B2_BA_N];
    byte1_one_dir = b1_ab_n != b1_ba_n;
    byte2_one_dir = b2_ab_n != b2_ba_n;
    bytes_agree = b1_ab_n == b2_ab_n;
    dir_valid = byte1_one_dir && byte2_one_dir && bytes_agree;
    a_to_b = dir_valid && (b1_ab_n == brt_pkg::OE_ACTIVE);
    running = sy.run && sy.idle && dir_valid;
  end

  // ****************************************************************
  // Operation datapath
  // ****************************************************************
  logic [brt_pkg::HALF_W-1:0] cells_a;
  logic [brt_pkg::HALF_W-1:0] cells_b;
  logic [brt_pkg::HALF_W-1:0] pins_in;
  logic [brt_pkg::HALF_W-1:0] in_half;
  logic [brt_pkg::HALF_W-1:0] out_half;
  logic [brt_pkg::HALF_W-1:0] sig18;
  logic [brt_pkg::HALF_W-1:0] pat18;
  logic [brt_pkg::HALF_W-1:0] cnt18;
  logic [brt_pkg::DATA_W-1:0] view;
  logic [brt_pkg::DATA_W-1:0] pat36;
  logic [brt_pkg::DATA_W-1:0] sig36;
  logic [brt_pkg::DATA_W-1:0] next_view;

  always_comb begin
    cells_a = st.shift[brt_pkg::A_LSB +: brt_pkg::HALF_W];
    cells_b = st.shift[brt_pkg::B_LSB +: brt_pkg::HALF_W];
    // Upper half of the view is always the input side, lower the output side.
    view = a_to_b ? {cells_a, cells_b} : {cells_b, cells_a};
    pins_in = a_to_b ? sy.a : sy.b;
    in_half = view[brt_pkg::DATA_W-1:brt_pkg::HALF_W];
    out_half = view[brt_pkg::HALF_W-1:0];
    pat36 = step36(view);
    sig36 = pat36 ^ {pins_in, {brt_pkg::HALF_W{1'b0}}};
    sig18 = step18(in_half) ^ pins_in;
    pat18 = step18(out_half);
    // The count wraps to zero after all ones; nothing flags the wrap.
    cnt18 = out_half + brt_pkg::COUNT_STEP;
  end

  always_comb begin
    case (op)
      brt_pkg::OP_TOGGLE: begin
        next_view = {pins_in, ~out_half};
      end
      brt_pkg::OP_PATTERN36: begin
        next_view = pat36;
      end
      brt_pkg::OP_SIGNATURE36: begin
        next_view = sig36;
      end
      brt_pkg::OP_SIG_PATTERN: begin
        next_view = {sig18, pat18};
      end
      brt_pkg::OP_SIG_COUNT: begin
        next_view = {sig18, cnt18};
      end
      default: begin
        next_view = view;
      end
    endcase
  end

  // ****************************************************************
  // Chain update
  // ****************************************************************
  logic [brt_pkg::HALF_W-1:0] next_in;
  logic [brt_pkg::HALF_W-1:0] next_out;
  logic step_rise;
  logic latch_outputs;
  logic frozen;

  always_comb begin
    next_in = next_view[brt_pkg::HALF_W +: brt_pkg::HALF_W];
    next_out = next_view[brt_pkg::HALF_W-1:0];
    step_rise = running && tck_rise;
    // Signature mode leaves the output latches frozen.
    latch_outputs = running && tck_fall && (op != brt_pkg::OP_SIGNATURE36);
    frozen = i_read_capture && !i_load_valid;
  end

  always_comb begin
    next_st = st;
    if (i_load_valid) begin
      next_st.shift = i_load_chain;
      next_st.shadow = i_load_chain;
    end else if (frozen) begin
      // A boundary-read capture changes nothing.
      next_st = st;
    end else if (step_rise) begin
      // Only bits 35 to 0 are written; the control cells keep their value.
      if (a_to_b) begin
        next_st.shift[brt_pkg::A_LSB +: brt_pkg::HALF_W] = next_in;
        next_st.shift[brt_pkg::B_LSB +: brt_pkg::HALF_W] = next_out;
      end else begin
        next_st.shift[brt_pkg::B_LSB +: brt_pkg::HALF_W] = next_in;
        next_st.shift[brt_pkg::A_LSB +: brt_pkg::HALF_W] = next_out;
      end
    end else if (latch_outputs) begin
      if (a_to_b) begin
        next_st.shadow[brt_pkg::B_LSB +: brt_pkg::HALF_W] = cells_b;
      end else begin
        next_st.shadow[brt_pkg::A_LSB +: brt_pkg::HALF_W] = cells_a;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '{shift: brt_pkg::CHAIN_RESET, shadow: brt_pkg::CHAIN_RESET};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Pins are driven only in test mode, which the run instruction selects.
  logic [brt_pkg::HALF_W-1:0] a_drive;
  logic [brt_pkg::HALF_W-1:0] b_drive;

  genvar gi;
  generate
    for (gi = 0; gi < brt_pkg::HALF_W; gi++) begin : g_pin
      localparam int AB_POS = (gi < brt_pkg::BYTE_W) ? brt_pkg::POS_B1_AB_N : brt_pkg::POS_B2_AB_N;
      localparam int BA_POS = (gi < brt_pkg::BYTE_W) ? brt_pkg::POS_B1_BA_N : brt_pkg::POS_B2_BA_N;
      assign a_drive[gi] = st.shadow[BA_POS] == brt_pkg::OE_ACTIVE;
      assign b_drive[gi] = st.shadow[AB_POS] == brt_pkg::OE_ACTIVE;
      assign o_pins.a_out[gi] = st.shadow[brt_pkg::A_LSB + gi];
      assign o_pins.b_out[gi] = st.shadow[brt_pkg::B_LSB + gi];
      assign o_pins.a_oe[gi] = sy.run && a_drive[gi];
      assign o_pins.b_oe[gi] = sy.run && b_drive[gi];
    end
  endgenerate

  assign o_boundary_chain = st.shift;
  assign o_shadow = st.shadow;
  assign o_running = running;
  assign o_bypass_active = sy.run && !dir_valid;
  assign o_a_to_b = a_to_b;

endmodule

// file: hdl/brt_pkg.sv
package brt_pkg;

  // ****************************************************************
  // Chain geometry
  // ****************************************************************
  localparam int CHAIN_W = 48;
  localparam int DATA_W = 36;
  localparam int HALF_W = 18;
  localparam int BYTE_W = 9;
  localparam int A_LSB = 18;
  localparam int B_LSB = 0;
  localparam int CTRL_LSB = 36;
  localparam int POS_B1_AB_N = 44;
  localparam int POS_B2_AB_N = 45;
  localparam int POS_B1_BA_N = 46;
  localparam int POS_B2_BA_N = 47;
  localparam logic OE_ACTIVE = 1'h0;
  localparam logic [CHAIN_W-1:0] CHAIN_RESET = 48'h0000_0000_0000;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  localparam logic [1:0] LOW_TOGGLE = 2'h0;
  localparam logic [1:0] LOW_PATTERN = 2'h1;
  localparam logic [1:0] LOW_SIGNATURE = 2'h2;
  localparam logic [2:0] CODE_SIG_PATTERN = 3'h3;
  localparam logic [2:0] CODE_SIG_COUNT = 3'h7;

  // ****************************************************************
  // Feedback taps
  // ****************************************************************
  // Both polynomials are maximal length: x^36 + x^25 + 1 and x^18 + x^11 + 1.
  localparam int TAP36_HI = 35;
  localparam int TAP36_LO = 24;
  localparam int TAP18_HI = 17;
  localparam int TAP18_LO = 10;
  localparam logic [HALF_W-1:0] COUNT_STEP = 18'h00001;

  typedef enum logic [2:0] {
    OP_TOGGLE,
    OP_PATTERN36,
    OP_SIGNATURE36,
    OP_SIG_PATTERN,
    OP_SIG_COUNT
  } test_op_t;

  typedef struct packed {
    logic tck;
    logic run;
    logic idle;
    logic [HALF_W-1:0] a;
    logic [HALF_W-1:0] b;
  } link_in_t;

  typedef struct packed {
    logic [HALF_W-1:0] a_out;
    logic [HALF_W-1:0] a_oe;
    logic [HALF_W-1:0] b_out;
    logic [HALF_W-1:0] b_oe;
  } pin_out_t;

  localparam int LINK_W = $bits(link_in_t);

endpackage

// file: hdl/link_sampler.sv
`timescale 1ns/100ps
module link_sampler #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous bundle, bit 0 is the test clock
  input wire logic [W-1:0] i_async,
  // Sampled bundle and test clock edges
  output logic [W-1:0] o_sync,
  output logic o_rise,
  output logic o_fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic last_tck;
  } sampler_t;

  sampler_t st;
  sampler_t next_st;

  // ****************************************************************
  // Two flip-flop crossing
  // ****************************************************************
  // The whole bundle moves together so pins and state line up with the
  // edge that is detected on the same stable copy.
  always_comb begin
    next_st = st;
    next_st.meta = i_async;
    next_st.stable = st.meta;
    next_st.last_tck = st.stable[0];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.stable;
  assign o_rise = st.stable[0] & ~st.last_tck;
  assign o_fall = ~st.stable[0] & st.last_tck;

endmodule

// file: verif/boundary_run_test_engine_props.sv
`timescale 1ns/100ps
module boundary_run_test_engine_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire brt_pkg::link_in_t i_link,
  input wire logic [2:0] i_test_op_select_reg,
  input wire logic i_load_valid,
  input wire logic [brt_pkg::CHAIN_W-1:0] i_load_chain,
  input wire logic i_read_capture,
  input wire brt_pkg::pin_out_t o_pins,
  input wire logic [brt_pkg::CHAIN_W-1:0] o_boundary_chain,
  input wire logic [brt_pkg::CHAIN_W-1:0] o_shadow,
  input wire logic o_running,
  input wire logic o_bypass_active,
  input wire logic o_a_to_b
);
  // ****
  // Checks
  // ****
  logic [47:0] c;
  assign c = o_boundary_chain;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_ctrl_kept: assert property (!i_load_valid |=> $stable(c[47:36]) && $stable(o_shadow[47:36]))
    else $error("control cells changed");
  a_oe_byte1: assert property (o_pins.a_oe[8:0] != 9'h000 |-> c[46] == brt_pkg::OE_ACTIVE)
    else $error("byte1 A drive without enable");
  a_oe_byte2: assert property (o_pins.b_oe[17:9] != 9'h000 |->
    o_pins.b_oe[17:9] == 9'h1FF && c[45] == brt_pkg::OE_ACTIVE)
    else $error("byte2 B drive wrong");
  a_run_dir: assert property (o_running |->
    c[44] != c[46] && c[45] != c[47] && c[44] == c[45] && !o_bypass_active)
    else $error("running with bad direction");
  a_dir_ab: assert property (o_a_to_b |-> !c[44] && c[46])
    else $error("direction flag wrong");
  a_halt_frozen: assert property (!o_running && !i_load_valid |=> $stable(c))
    else $error("chain moved while halted");
  a_capture_hold: assert property (i_read_capture && !i_load_valid |=>
    $stable(c) && $stable(o_shadow))
    else $error("chain moved during capture");
  a_pins_shadow: assert property ({o_pins.a_out, o_pins.b_out} == o_shadow[35:0])
    else $error("pins differ from shadow");
  a_psa_shadow: assert property (o_running && i_test_op_select_reg[1:0] == brt_pkg::LOW_SIGNATURE &&
    !i_load_valid |=> $stable(o_shadow))
    else $error("shadow moved in signature mode");
endmodule
bind boundary_run_test_engine boundary_run_test_engine_props i_props (.i_clk(i_clk),
  .i_rst(i_rst), .i_link(i_link), .i_test_op_select_reg(i_test_op_select_reg),
  .i_load_valid(i_load_valid), .i_load_chain(i_load_chain), .i_read_capture(i_read_capture),
  .o_pins(o_pins), .o_boundary_chain(o_boundary_chain), .o_shadow(o_shadow),
  .o_running(o_running), .o_bypass_active(o_bypass_active), .o_a_to_b(o_a_to_b));

// file: verif/tb_boundary_run_test_engine.sv
`timescale 1ns/100ps
module tb_boundary_run_test_engine;
  // ****
  // Bench
  // ****
  typedef struct packed {logic [47:0] sh; logic [47:0] sd;} exp_t;
  logic i_clk = 1'h0, i_rst = 1'h1, ld = 1'h0, cap = 1'h0, go = 1'h0, step, busy;
  logic [2:0] code = 3'h0;
  logic [47:0] img = '0, ch, sd;
  logic [17:0] pa = '0, pb = '0;
  logic [3:0] n = 4'h0;
  brt_pkg::link_in_t link, ml;
  brt_pkg::pin_out_t p;
  exp_t q[$];
  int num_errors = 0, n_compared = 0;
  always #4 i_clk = ~i_clk;
  assign link = {ml.tck, ml.run, ml.idle, (p.a_oe & p.a_out) | (~p.a_oe & ml.a),
    (p.b_oe & p.b_out) | (~p.b_oe & ml.b)};
  boundary_run_test_engine i_boundary_run_test_engine (.i_clk(i_clk), .i_rst(i_rst),
    .i_link(link), .i_test_op_select_reg(code), .i_load_valid(ld), .i_load_chain(img),
    .i_read_capture(cap), .o_pins(p), .o_boundary_chain(ch), .o_shadow(sd), .o_running(),
    .o_bypass_active(), .o_a_to_b());
  test_port_model i_test_port_model (.i_clk(i_clk), .i_go(go), .i_n(n), .i_a(pa), .i_b(pb),
    .o_link(ml), .o_step(step), .o_busy(busy));
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [35:0] step_ref(logic [35:0] v, logic [2:0] c, logic [17:0] s);
    logic [17:0] i, o;
    i = v[35:18];
    o = v[17:0];
    case (c[1:0])
      2'h0: return {s, ~o};
      2'h1: return {v[34:0], v[35] ^ v[24]};
      2'h2: return {v[34:0], v[35] ^ v[24]} ^ {s, 18'h00000};
      default: return {{i[16:0], i[17] ^ i[10]} ^ s,
        c[2] ? o + 18'h00001 : {o[16:0], o[17] ^ o[10]}};
    endcase
  endfunction
  // Expected images are queued per test clock cycle, before the frame starts.
  task automatic run_case(input logic [2:0] c, input logic [11:0] k, input logic [35:0] d,
    input logic fz, input logic [3:0] m);
    logic [35:0] v, s;
    logic ab, ok;
    int w;
    ok = k[8] != k[10] && k[9] != k[11] && k[8] == k[9];
    ab = ok && !k[8];
    v = ab ? d : {d[17:0], d[35:18]};
    s = v;
    pa = 18'($urandom);
    pb = 18'($urandom);
    for (w = 0; w < m; w++) begin
      if (ok && !fz) begin
        v = step_ref(v, c, ab ? pa : pb);
        if (c[1:0] != 2'h2) s[17:0] = v[17:0];
      end
      q.push_back({k, ab ? v : {v[17:0], v[35:18]}, k, ab ? s : {s[17:0], s[35:18]}});
    end
    @(posedge i_clk);
    #1 ld = 1'h1;
    img = {k, d};
    code = c;
    cap = fz;
    @(posedge i_clk);
    #1 ld = 1'h0;
    go = 1'h1;
    n = m;
    @(posedge i_clk);
    #1 go = 1'h0;
    repeat (3) @(posedge i_clk);
    for (w = 0; busy === 1'h1 && w < 2000; w++) @(posedge i_clk);
    if (w == 2000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: frame hung", $time);
    end
    #1 cap = 1'h0;
  endtask
  always @(posedge i_clk) begin
    if (step === 1'h1) begin
      if (q.size() == 0) begin
        num_errors++;
        $display("CHECK FAILED at %0t: unexpected step", $time);
      end else begin
        cmp(ch, q[0].sh);
        cmp(sd, q[0].sd);
        void'(q.pop_front());
      end
    end
  end
  task automatic finish_test;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h9132));
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'h0;
    for (int r = 0; r < 16; r++) begin
      run_case(3'(r), {r[3] ? 4'h3 : 4'hC, 8'($urandom)}, 36'({$urandom, $urandom}), 1'h0, 4'h3);
    end
    run_case(3'h1, 12'hC00, 36'h0, 1'h0, 4'h4);
    run_case(3'h3, 12'h3A5, 36'h0, 1'h0, 4'h4);
    run_case(3'h2, 12'h5FF, 36'({$urandom, $urandom}), 1'h0, 4'h3);
    run_case(3'h0, 12'hC11, 36'({$urandom, $urandom}), 1'h1, 4'h3);
    repeat (4) @(posedge i_clk);
    if (q.size() != 0) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %0d expected results never seen", $time, q.size());
    end
    finish_test();
  end
endmodule

// file: verif/test_port_model.sv
`timescale 1ns/100ps
module test_port_model (
  // Clock and frame request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_n,
  input wire logic [17:0] i_a,
  input wire logic [17:0] i_b,
  // Test port and progress
  output brt_pkg::link_in_t o_link,
  output logic o_step,
  output logic o_busy
);
  // ****
  // Frames
  // ****
  // The test clock stands low between frames, so no stray edge reaches the block.
  initial begin
    o_link = '0;
    o_step = 1'h0;
    o_busy = 1'h0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        #1 o_busy = 1'h1;
        o_link.a = i_a;
        o_link.b = i_b;
        o_link.run = 1'h1;
        o_link.idle = 1'h1;
        repeat (6) @(posedge i_clk);
        for (int k = 0; k < i_n; k++) begin
          #1 o_link.tck = 1'h1;
          o_step = 1'h0;
          repeat (5) @(posedge i_clk);
          #1 o_link.tck = 1'h0;
          repeat (4) @(posedge i_clk);
          #1 o_step = 1'h1;
          @(posedge i_clk);
        end
        #1 o_step = 1'h0;
        repeat (4) @(posedge i_clk);
        #1 o_link.run = 1'h0;
        o_link.idle = 1'h0;
        o_busy = 1'h0;
      end
    end
  end
endmodule
